// file: include/sensor_fifo_pkg.sv
package sensor_fifo_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] LEVEL_HIGH_OFFSET = 8'h72;
  localparam logic [7:0] LEVEL_LOW_OFFSET  = 8'h73;
  localparam logic [7:0] DATA_PORT_OFFSET  = 8'h74;
  localparam logic [7:0] IDENTITY_OFFSET   = 8'h75;

  ////////////////////////////////////////////////////////////////////////
  // identity: value is arbitrary
  localparam logic [5:0] IDENTITY_UPPER = 6'h2a;
  localparam int         IDENTITY_LSB   = 1;
  localparam logic [7:0] UNMAPPED_DATA  = 8'h00;
  localparam logic [7:0] DATA_RESET     = 8'h00;
  localparam logic [15:0] LEVEL_RESET   = 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // fifo geometry
  localparam int DATA_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int COUNT_W    = $clog2(FIFO_DEPTH + 1);

  ////////////////////////////////////////////////////////////////////////
  // sensor data layout, registers 59 to 96
  localparam int FIRST_SENSOR_REG = 59;
  localparam int SENSOR_BYTES     = 38;
  localparam int IDX_W            = 6;
  localparam int ACCEL_FIRST      = 0;
  localparam int TEMP_FIRST       = 6;
  localparam int GYRO_X_FIRST     = 8;
  localparam int GYRO_Y_FIRST     = 10;
  localparam int GYRO_Z_FIRST     = 12;
  localparam int EXT_FIRST        = 14;
  localparam int EXT_BYTES        = 24;

  ////////////////////////////////////////////////////////////////////////
  // source enable bit positions
  localparam int EN_TEMP   = 7;
  localparam int EN_GYRO_X = 6;
  localparam int EN_GYRO_Y = 5;
  localparam int EN_GYRO_Z = 4;
  localparam int EN_ACCEL  = 3;
  localparam int EN_SLAVE2 = 2;
  localparam int EN_SLAVE1 = 1;
  localparam int EN_SLAVE0 = 0;

  ////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_WALK = 1'b1
  } seq_state_e;

  typedef struct packed {
    logic       strobe;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic       assigned;
    logic [1:0] slave;
  } ext_slot_s;

endpackage

// file: verilog/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       flush,
  // fill side
  input  wire logic                       inValid,
  output logic                            inReady,
  input  wire logic [WIDTH-1:0]           inData,
  // drain side
  output logic                            outValid,
  input  wire logic                       outReady,
  output logic [WIDTH-1:0]                outData,
  // occupancy
  output logic [$clog2(DEPTH+1)-1:0]      count
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0]         mem [DEPTH];
  logic [PTR_W-1:0]         wrPtr_reg;
  logic [PTR_W-1:0]         rdPtr_reg;
  logic [$clog2(DEPTH+1)-1:0] count_reg;
  logic                     doPush;
  logic                     doPop;
  logic                     full;

  assign full     = (count_reg == ($clog2(DEPTH+1))'(DEPTH));
  assign outValid = (count_reg != '0);
  // a full fifo still accepts when the same cycle drains a word
  assign inReady  = !full || outReady;
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;
  assign outData  = mem[rdPtr_reg];
  assign count    = count_reg;

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || flush) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doPush) begin
        wrPtr_reg <= (wrPtr_reg == LAST) ? '0 : wrPtr_reg + 1'b1;
      end
      if (doPop) begin
        rdPtr_reg <= (rdPtr_reg == LAST) ? '0 : rdPtr_reg + 1'b1;
      end
      if (doPush && !doPop) begin
        count_reg <= count_reg + 1'b1;
      end else if (doPop && !doPush) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// file: verilog/sensor_fifo_readout_and_id.sv
// What this block does
// - level reported as 16 bits, two bytes
// - high byte read latches both level bytes
// - low byte read alone refreshes nothing
// - samples pushed in ascending register order
// - all enabled, ext slots assigned: registers 59 to 96 pushed
// - group pushed only when enable flag set
// - slave three uses master control enable
// - overflow sets the overflow flag
// - overflow drops oldest, keeps newest data
// - empty read repeats last popped byte
// - data port moves one byte per access
// - level equals bytes available to read
// - identity bits six to one: address
// - address select pin absent from identity
// - identity bits zero and seven zero
// - reset bit empties fifo once the fifo is disabled, then self-clears
`timescale 1ns/1ps
module sensor_fifo_readout_and_id (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst_b,
  // serial register interface, decoded
  input  wire sensor_fifo_pkg::reg_req_s       regReq,
  output logic [7:0]                           regRdata,
  output logic                                 regRvalid,
  // sample data sources
  input  wire logic                            sampleTick,
  input  wire logic [37:0][7:0]                sensorBytes,
  input  wire sensor_fifo_pkg::ext_slot_s [23:0] extSlots,
  // control bits held elsewhere
  input  wire logic [7:0]                      sourceEnable,
  input  wire logic                            slave3Enable,
  input  wire logic                            fifoEnable,
  input  wire logic                            fifoResetWrite,
  input  wire logic                            overflowClear,
  // status
  output logic                                 fifoOverflowFlag,
  output logic                                 fifoResetPending,
  // address pin and resulting bus address
  input  wire logic                            addressSelectPin,
  output logic [6:0]                           deviceAddress
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0]                          snap_reg [sensor_fifo_pkg::SENSOR_BYTES];
  sensor_fifo_pkg::seq_state_e         seqState_reg;
  logic [sensor_fifo_pkg::IDX_W-1:0]   seqIdx_reg;
  logic [7:0]                          levelHigh_reg;
  logic [7:0]                          levelLow_reg;
  logic [7:0]                          lastPopped_reg;
  logic [7:0]                          regRdata_reg;
  logic                                regRvalid_reg;
  logic                                overflow_reg;
  logic                                resetPending_reg;
  logic [6:0]                          address_reg;
  logic                                pinMeta_reg;
  logic                                pinSync_reg;
  logic [15:0]                         liveLevel;
  logic [sensor_fifo_pkg::COUNT_W-1:0] fifoCount;
  logic                                fifoFull;
  logic                                inReady;
  logic                                outValid;
  logic                                outReady;
  logic [7:0]                          outData;
  logic                                inValid;
  logic [7:0]                          inData;
  logic                                hostRead;
  logic                                hostWrite;
  logic                                readHigh;
  logic                                readLow;
  logic                                readData;
  logic                                readId;
  logic                                writeData;
  logic                                seqWants;
  logic                                seqPush;
  logic                                seqAdvance;
  logic                                dropOldest;
  logic                                flushNow;

  ////////////////////////////////////////////////////////////////////////
  // source enable decode per byte of the sample block
  function automatic logic byteOn(
    input logic [sensor_fifo_pkg::IDX_W-1:0] idx,
    input logic [7:0]                        en,
    input logic                              en3,
    input sensor_fifo_pkg::ext_slot_s [23:0] slots
  );
    logic                                 on;
    logic [sensor_fifo_pkg::IDX_W-1:0]    ext;
    sensor_fifo_pkg::ext_slot_s           slot;
    on   = 1'b0;
    ext  = idx - sensor_fifo_pkg::IDX_W'(sensor_fifo_pkg::EXT_FIRST);
    slot = slots[ext[4:0]];
    if (idx < sensor_fifo_pkg::IDX_W'(sensor_fifo_pkg::TEMP_FIRST)) begin
      on = en[sensor_fifo_pkg::EN_ACCEL];
    end else if (idx < sensor_fifo_pkg::IDX_W'(sensor_fifo_pkg::GYRO_X_FIRST)) begin
      on = en[sensor_fifo_pkg::EN_TEMP];
    end else if (idx < sensor_fifo_pkg::IDX_W'(sensor_fifo_pkg::GYRO_Y_FIRST)) begin
      on = en[sensor_fifo_pkg::EN_GYRO_X];
    end else if (idx < sensor_fifo_pkg::IDX_W'(sensor_fifo_pkg::GYRO_Z_FIRST)) begin
      on = en[sensor_fifo_pkg::EN_GYRO_Y];
    end else if (idx < sensor_fifo_pkg::IDX_W'(sensor_fifo_pkg::EXT_FIRST)) begin
      on = en[sensor_fifo_pkg::EN_GYRO_Z];
    end else if (slot.assigned) begin
      unique case (slot.slave)
        2'h0: on = en[sensor_fifo_pkg::EN_SLAVE0];
        2'h1: on = en[sensor_fifo_pkg::EN_SLAVE1];
        2'h2: on = en[sensor_fifo_pkg::EN_SLAVE2];
        2'h3: on = en3;
      endcase
    end
    return on;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register access decode
  assign hostRead  = regReq.strobe && !regReq.write;
  assign hostWrite = regReq.strobe && regReq.write;
  assign readHigh  = hostRead && (regReq.addr == sensor_fifo_pkg::LEVEL_HIGH_OFFSET);
  assign readLow   = hostRead && (regReq.addr == sensor_fifo_pkg::LEVEL_LOW_OFFSET);
  assign readData  = hostRead && (regReq.addr == sensor_fifo_pkg::DATA_PORT_OFFSET);
  assign readId    = hostRead && (regReq.addr == sensor_fifo_pkg::IDENTITY_OFFSET);
  assign writeData = hostWrite && (regReq.addr == sensor_fifo_pkg::DATA_PORT_OFFSET);

  ////////////////////////////////////////////////////////////////////////
  // sample buffer
  assign liveLevel  = {{(16 - sensor_fifo_pkg::COUNT_W){1'b0}}, fifoCount};
  assign fifoFull   = (fifoCount == sensor_fifo_pkg::COUNT_W'(sensor_fifo_pkg::FIFO_DEPTH));
  assign flushNow   = resetPending_reg && !fifoEnable;
  assign seqWants   = (seqState_reg == sensor_fifo_pkg::SEQ_WALK)
                      && byteOn(seqIdx_reg, sourceEnable, slave3Enable, extSlots);
  // host writes win the fill side; the walk waits a cycle
  assign seqPush    = seqWants && !writeData;
  assign inValid    = writeData || seqPush;
  assign inData     = writeData ? regReq.wdata : snap_reg[seqIdx_reg];
  assign dropOldest = inValid && fifoFull && !readData;
  assign outReady   = (readData && outValid) || dropOldest;
  assign seqAdvance = (seqState_reg == sensor_fifo_pkg::SEQ_WALK)
                      && (!seqWants || (seqPush && inReady));

  byte_fifo #(
    .WIDTH (sensor_fifo_pkg::DATA_WIDTH),
    .DEPTH (sensor_fifo_pkg::FIFO_DEPTH)
  ) u_byte_fifo (
    .clk      (clk),
    .rst_b    (rst_b),
    .flush    (flushNow),
    .inValid  (inValid),
    .inReady  (inReady),
    .inData   (inData),
    .outValid (outValid),
    .outReady (outReady),
    .outData  (outData),
    .count    (fifoCount)
  );

  ////////////////////////////////////////////////////////////////////////
  // sample walk: snapshot on tick, then push bytes in order
  always_ff @(posedge clk) begin
    if ((seqState_reg == sensor_fifo_pkg::SEQ_IDLE) && sampleTick) begin
      for (int i = 0; i < sensor_fifo_pkg::SENSOR_BYTES; i++) begin
        snap_reg[i] <= sensorBytes[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || flushNow) begin
      seqState_reg <= sensor_fifo_pkg::SEQ_IDLE;
      seqIdx_reg   <= '0;
    end else begin
      unique case (seqState_reg)
        sensor_fifo_pkg::SEQ_IDLE: begin
          if (sampleTick && fifoEnable) begin
            seqState_reg <= sensor_fifo_pkg::SEQ_WALK;
            seqIdx_reg   <= '0;
          end
        end
        sensor_fifo_pkg::SEQ_WALK: begin
          if (seqAdvance) begin
            if (seqIdx_reg == sensor_fifo_pkg::IDX_W'(sensor_fifo_pkg::SENSOR_BYTES - 1)) begin
              seqState_reg <= sensor_fifo_pkg::SEQ_IDLE;
            end else begin
              seqIdx_reg <= seqIdx_reg + 1'b1;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // level shadow pair
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      levelHigh_reg <= sensor_fifo_pkg::LEVEL_RESET[15:8];
      levelLow_reg  <= sensor_fifo_pkg::LEVEL_RESET[7:0];
    end else if (readHigh) begin
      levelHigh_reg <= liveLevel[15:8];
      levelLow_reg  <= liveLevel[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // last byte popped, repeated on empty reads
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lastPopped_reg <= sensor_fifo_pkg::DATA_RESET;
    end else if (readData && outValid) begin
      lastPopped_reg <= outData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read answer, one cycle after the request
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      regRdata_reg  <= sensor_fifo_pkg::UNMAPPED_DATA;
      regRvalid_reg <= 1'b0;
    end else begin
      regRvalid_reg <= hostRead;
      if (readHigh) begin
        regRdata_reg <= liveLevel[15:8];
      end else if (readLow) begin
        regRdata_reg <= levelLow_reg;
      end else if (readData) begin
        regRdata_reg <= outValid ? outData : lastPopped_reg;
      end else if (readId) begin
        regRdata_reg <= {1'b0, sensor_fifo_pkg::IDENTITY_UPPER, 1'b0};
      end else if (hostRead) begin
        regRdata_reg <= sensor_fifo_pkg::UNMAPPED_DATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // overflow flag, a new overflow beats a clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      overflow_reg <= 1'b0;
    end else if (dropOldest) begin
      overflow_reg <= 1'b1;
    end else if (overflowClear) begin
      overflow_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fifo reset bit: held until the fifo is disabled, then clears itself
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      resetPending_reg <= 1'b0;
    end else if (fifoResetWrite) begin
      resetPending_reg <= 1'b1;
    end else if (flushNow) begin
      resetPending_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address select pin synchroniser and bus address
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pinMeta_reg <= 1'b0;
      pinSync_reg <= 1'b0;
    end else begin
      pinMeta_reg <= addressSelectPin;
      pinSync_reg <= pinMeta_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      address_reg <= {sensor_fifo_pkg::IDENTITY_UPPER, 1'b0};
    end else begin
      address_reg <= {sensor_fifo_pkg::IDENTITY_UPPER, pinSync_reg};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign regRdata         = regRdata_reg;
  assign regRvalid        = regRvalid_reg;
  assign fifoOverflowFlag = overflow_reg;
  assign fifoResetPending = resetPending_reg;
  assign deviceAddress    = address_reg;

endmodule

// file: bench/sensor_host_model.sv
`timescale 1ns/1ps
module sensor_host_model (
  // clock
  input  wire logic                      clk,
  // decoded register interface
  output sensor_fifo_pkg::reg_req_s      regReq,
  input  wire logic [7:0]                regRdata,
  input  wire logic                      regRvalid
);
  initial regReq = '0;

  ////////////////////////////////////////////////////////////////////////
  // one byte per access, strobe seen at exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regReq = '{strobe: 1'b1, write: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    regReq.strobe = 1'b0;
    regReq.wdata  = ~d;
  endtask

  // answer must be up the cycle after the strobe, otherwise unknown
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regReq = '{strobe: 1'b1, write: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clk);
    regReq.strobe = 1'b0;
    d = (regRvalid === 1'b1) ? regRdata : 8'hxx;
  endtask
endmodule

// file: bench/sensor_fifo_properties.sv
`timescale 1ns/1ps
module sensor_fifo_checker (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // register interface
  input  wire sensor_fifo_pkg::reg_req_s regReq,
  input  wire logic [7:0]                regRdata,
  input  wire logic                      regRvalid,
  // control and status
  input  wire logic                      fifoEnable,
  input  wire logic                      fifoResetWrite,
  input  wire logic                      overflowClear,
  input  wire logic                      fifoOverflowFlag,
  input  wire logic                      fifoResetPending,
  input  wire logic [6:0]                deviceAddress
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence anyRead;
    regReq.strobe && !regReq.write;
  endsequence
  sequence readOf(a);
    regReq.strobe && !regReq.write && regReq.addr == a;
  endsequence
  sequence flushReady;
    fifoResetPending && !fifoEnable && !fifoResetWrite;
  endsequence

  chk_read_answer_once: assert property (anyRead |=> regRvalid)
    else $error("read strobe got no answer next cycle");
  chk_valid_has_cause: assert property (regRvalid |-> $past(regReq.strobe && !regReq.write))
    else $error("answer without a read strobe");
  chk_identity_value: assert property (readOf(sensor_fifo_pkg::IDENTITY_OFFSET)
    |=> regRdata == {1'b0, sensor_fifo_pkg::IDENTITY_UPPER, 1'b0})
    else $error("identity read wrong");
  chk_unmapped_zero: assert property (anyRead ##0 (regReq.addr < sensor_fifo_pkg::LEVEL_HIGH_OFFSET
    || regReq.addr > sensor_fifo_pkg::IDENTITY_OFFSET)
    |=> regRdata == sensor_fifo_pkg::UNMAPPED_DATA)
    else $error("unmapped read not zero");
  chk_level_high_zero: assert property (readOf(sensor_fifo_pkg::LEVEL_HIGH_OFFSET) |=> regRdata == 8'h00)
    else $error("level high byte above depth");
  chk_rdata_holds: assert property (!(regReq.strobe && !regReq.write) |=> $stable(regRdata))
    else $error("read data moved without a read");
  chk_address_upper: assert property (deviceAddress[6:1] == sensor_fifo_pkg::IDENTITY_UPPER)
    else $error("bus address upper bits wrong");
  chk_flag_sticky: assert property (fifoOverflowFlag && !overflowClear |=> fifoOverflowFlag)
    else $error("overflow flag dropped without clear");
  chk_reset_bit_sets: assert property (fifoResetWrite |=> fifoResetPending)
    else $error("fifo reset bit not set");
  chk_reset_bit_clears: assert property (flushReady |=> !fifoResetPending)
    else $error("fifo reset bit did not clear");
  chk_reset_bit_waits: assert property (fifoResetPending && fifoEnable |=> fifoResetPending)
    else $error("fifo reset bit cleared while enabled");
endmodule

bind sensor_fifo_readout_and_id sensor_fifo_checker u_sensor_fifo_checker (
  .clk              (clk),
  .rst_b            (rst_b),
  .regReq           (regReq),
  .regRdata         (regRdata),
  .regRvalid        (regRvalid),
  .fifoEnable       (fifoEnable),
  .fifoResetWrite   (fifoResetWrite),
  .overflowClear    (overflowClear),
  .fifoOverflowFlag (fifoOverflowFlag),
  .fifoResetPending (fifoResetPending),
  .deviceAddress    (deviceAddress)
);

// file: bench/sensor_fifo_readout_and_id_tb.sv
`timescale 1ns/1ps
module sensor_fifo_readout_and_id_tb;
  logic                              clk;
  logic                              rst_b;
  sensor_fifo_pkg::reg_req_s         regReq;
  logic [7:0]                        regRdata;
  logic                              regRvalid;
  logic                              sampleTick;
  logic [37:0][7:0]                  sensorBytes;
  sensor_fifo_pkg::ext_slot_s [23:0] extSlots;
  logic [7:0]                        sourceEnable;
  logic                              slave3Enable;
  logic                              fifoEnable;
  logic                              fifoResetWrite;
  logic                              overflowClear;
  logic                              fifoOverflowFlag;
  logic                              fifoResetPending;
  logic                              addressSelectPin;
  logic [6:0]                        deviceAddress;
  logic [37:0]                       mask3;
  logic [7:0]                        idVal;
  int                                miscompares;
  int                                comparisons;
  int                                cycles;

  initial clk = 1'b0;
  always #4 clk = ~clk;

  sensor_fifo_readout_and_id u_sensor_fifo_readout_and_id (.clk(clk), .rst_b(rst_b), .regReq(regReq),
    .regRdata(regRdata), .regRvalid(regRvalid), .sampleTick(sampleTick), .sensorBytes(sensorBytes),
    .extSlots(extSlots), .sourceEnable(sourceEnable), .slave3Enable(slave3Enable), .fifoEnable(fifoEnable),
    .fifoResetWrite(fifoResetWrite), .overflowClear(overflowClear), .fifoOverflowFlag(fifoOverflowFlag),
    .fifoResetPending(fifoResetPending), .addressSelectPin(addressSelectPin), .deviceAddress(deviceAddress));
  sensor_host_model u_sensor_host_model (.clk(clk), .regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic expectRd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_sensor_host_model.rd(a, d);
    check(d, e);
  endtask

  task automatic expectLevel(input int n);
    expectRd(sensor_fifo_pkg::LEVEL_HIGH_OFFSET, 8'h00);
    expectRd(sensor_fifo_pkg::LEVEL_LOW_OFFSET, n[7:0]);
  endtask

  task automatic pushes(input int n, input logic [7:0] first);
    for (int i = 0; i < n; i++) u_sensor_host_model.wr(sensor_fifo_pkg::DATA_PORT_OFFSET, first + i[7:0]);
  endtask

  task automatic pops(input int n, input logic [7:0] first);
    for (int i = 0; i < n; i++) expectRd(sensor_fifo_pkg::DATA_PORT_OFFSET, first + i[7:0]);
  endtask

  // expected bytes: marked indices in ascending order, newest 16 kept
  task automatic sample(input logic [7:0] en, input logic en3, input logic [37:0] mask);
    logic [7:0] q[$];
    sourceEnable = en;
    slave3Enable = en3;
    sampleTick   = 1'b1;
    @(negedge clk);
    sampleTick = 1'b0;
    repeat (42) @(negedge clk);
    for (int i = 0; i < 38; i++) if (mask[i]) q.push_back(sensorBytes[i]);
    while (q.size() > 16) q.pop_front();
    expectLevel(q.size());
    foreach (q[i]) expectRd(sensor_fifo_pkg::DATA_PORT_OFFSET, q[i]);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    sampleTick = 1'b0;
    sourceEnable = 8'h00;
    slave3Enable = 1'b0;
    fifoEnable = 1'b1;
    fifoResetWrite = 1'b0;
    overflowClear = 1'b0;
    addressSelectPin = 1'b0;
    mask3 = '0;
    for (int i = 0; i < 38; i++) sensorBytes[i] = 8'h40 + i[7:0];
    for (int k = 0; k < 24; k++) extSlots[k] = '{assigned: 1'b1, slave: k[1:0]};
    for (int k = 3; k < 24; k += 4) mask3[14+k] = 1'b1;
    idVal = {1'b0, sensor_fifo_pkg::IDENTITY_UPPER, 1'b0};
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    expectRd(sensor_fifo_pkg::IDENTITY_OFFSET, idVal);
    addressSelectPin = 1'b1;
    repeat (4) @(negedge clk);
    check({1'b0, deviceAddress}, {1'b0, sensor_fifo_pkg::IDENTITY_UPPER, 1'b1});
    expectRd(sensor_fifo_pkg::IDENTITY_OFFSET, idVal);
    expectRd(8'h10, sensor_fifo_pkg::UNMAPPED_DATA);
    expectRd(sensor_fifo_pkg::DATA_PORT_OFFSET, sensor_fifo_pkg::DATA_RESET);
    pushes(3, 8'h01);
    expectLevel(3);
    pushes(1, 8'h04);
    expectRd(sensor_fifo_pkg::LEVEL_LOW_OFFSET, 8'h03);
    expectLevel(4);
    pops(4, 8'h01);
    expectLevel(0);
    expectRd(sensor_fifo_pkg::DATA_PORT_OFFSET, 8'h04);
    expectRd(sensor_fifo_pkg::DATA_PORT_OFFSET, 8'h04);
    check({7'h00, fifoOverflowFlag}, 8'h00);
    pushes(18, 8'h10);
    check({7'h00, fifoOverflowFlag}, 8'h01);
    expectLevel(16);
    pops(16, 8'h12);
    overflowClear = 1'b1;
    @(negedge clk);
    overflowClear = 1'b0;
    @(negedge clk);
    check({7'h00, fifoOverflowFlag}, 8'h00);
    sample(8'h08, 1'b0, 38'h3f);
    sample(8'h90, 1'b0, 38'h30c0);
    sample(8'h00, 1'b1, mask3);
    sample(8'hff, 1'b1, '1);
    pushes(3, 8'h20);
    fifoResetWrite = 1'b1;
    @(negedge clk);
    fifoResetWrite = 1'b0;
    @(negedge clk);
    check({7'h00, fifoResetPending}, 8'h01);
    expectLevel(3);
    fifoEnable = 1'b0;
    repeat (2) @(negedge clk);
    check({7'h00, fifoResetPending}, 8'h00);
    expectLevel(0);
    wrap_up();
  end
endmodule
